//--- bench/pcio_pins.sv
// board-side pin model: resolves port drive, board drive and floating lines
`timescale 1ns/100ps
`default_nettype none
module pcio_pins (
  input  wire logic       CLOCK,    // core clock
  input  wire logic [7:0] pin_out,  // port drive value
  input  wire logic [7:0] pin_oe,   // port drive enable
  input  wire logic [7:0] ext_val,  // board drive value
  input  wire logic [7:0] ext_en,   // board drives pin
  output logic      [7:0] lvl       // resolved level
);
  logic [7:0] flt = 8'h55;
  // undriven lines wander every cycle
  always_ff @(posedge CLOCK) begin
    flt <= ~flt;
  end
  assign lvl = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & flt)));
endmodule
`default_nettype wire

//--- bench/pcio_port_tb.sv
// self-checking bench for the port block
`timescale 1ns/100ps
`default_nettype none
module pcio_port_tb;
  import pcio_pkg::*;
  logic CLOCK = 0, NRST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic CAPTURE_COMPARE_UNIT_TWO_EN = 0, CAPTURE_COMPARE_UNIT_TWO_OUT = 0, ECCP_EN = 0, ECCP_OUT = 0, PWM_SHUTDOWN = 0;
  logic SPI_CLK_EN = 0, SPI_CLK_OUT = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic OSC_ACTIVE, CAPTURE_COMPARE_UNIT_TWO_CAPTURE_IN, ECCP_CAPTURE_IN, SPI_CLK_IN, COUNTER_CLK_IN;
  logic [1:0] BRESP, RRESP;
  logic [3:0] WSTRB = 4'hF;
  logic [31:0] WDATA = 0, RDATA;
  logic [7:0] AWADDR = 0, ARADDR = 0, PIN_IN, PIN_OUT, PIN_OE, PERIPH_IN;
  logic [7:0] SER_OVR_EN = 0, SER_OVR_DRIVE = 0, SER_OVR_DATA = 0, ext_val = 0, ext_en = 0;
  logic [7:0] d, l, se, sd, sv, x, m, o;
  logic [15:0] lfsr = 16'h9600;
  int failures = 0;
  int checks = 0;
  pcio_port i_dut (.CLOCK(CLOCK), .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .CAPTURE_COMPARE_UNIT_TWO_EN(CAPTURE_COMPARE_UNIT_TWO_EN),
    .CAPTURE_COMPARE_UNIT_TWO_OUT(CAPTURE_COMPARE_UNIT_TWO_OUT), .ECCP_EN(ECCP_EN), .ECCP_OUT(ECCP_OUT),
    .PWM_SHUTDOWN(PWM_SHUTDOWN), .SPI_CLK_EN(SPI_CLK_EN), .SPI_CLK_OUT(SPI_CLK_OUT),
    .SER_OVR_EN(SER_OVR_EN), .SER_OVR_DRIVE(SER_OVR_DRIVE), .SER_OVR_DATA(SER_OVR_DATA),
    .OSC_ACTIVE(OSC_ACTIVE), .CAPTURE_COMPARE_UNIT_TWO_CAPTURE_IN(CAPTURE_COMPARE_UNIT_TWO_CAPTURE_IN),
    .ECCP_CAPTURE_IN(ECCP_CAPTURE_IN), .SPI_CLK_IN(SPI_CLK_IN),
    .COUNTER_CLK_IN(COUNTER_CLK_IN), .PERIPH_IN(PERIPH_IN));
  pcio_pins i_pins (.CLOCK(CLOCK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext_val(ext_val),
    .ext_en(ext_en), .lvl(PIN_IN));
  always #5 CLOCK = ~CLOCK;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  function automatic logic [1:0] f_resp(logic [7:0] a);
    return (a > ADDR_DRIVE_STAT) ? RESP_SLVERR : RESP_OKAY;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    AWADDR <= a;
    WDATA <= {24'h0, v};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    @(posedge CLOCK);
    while (AWVALID || WVALID) begin
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      @(posedge CLOCK);
    end
    BREADY <= 1'b1;
    do @(posedge CLOCK); while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    chk(BRESP, f_resp(a));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do @(posedge CLOCK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    RREADY <= 1'b1;
    do @(posedge CLOCK); while (RVALID !== 1'b1);
    RREADY <= 1'b0;
    chk(RRESP, f_resp(a));
    chk(RDATA & mk, e & mk);
  endtask
  task automatic test_done();
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    test_done();
  end
  initial begin
    NRST <= 1'b0;
    repeat (6) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    chk(PIN_OE, 8'h00);
    rd(ADDR_DIRECTION, 32'hFF, 32'hFFFFFFFF);
    rd(ADDR_CONTROL, 32'h2, 32'hFFFFFFFF);
    repeat (30) begin
      d = rnd();
      l = rnd();
      se = rnd() & rnd();
      sd = rnd();
      sv = rnd();
      x = rnd();
      m = rnd();
      o = (se & sd) | (~se & ~d);
      SER_OVR_EN <= se;
      SER_OVR_DRIVE <= sd;
      SER_OVR_DATA <= sv;
      ext_en <= ~o & m;
      ext_val <= x;
      wr(ADDR_DIRECTION, d);
      wr(l[0] ? ADDR_PIN_DATA : ADDR_OUT_LATCH, l);
      repeat (4) @(posedge CLOCK);
      chk(PIN_OE, o);
      chk(PIN_OUT & o, ((se & sv) | (~se & l)) & o);
      rd(ADDR_OUT_LATCH, l, 32'hFFFFFFFF);
      rd(ADDR_DIRECTION, d, 32'hFFFFFFFF);
      rd(ADDR_PIN_DATA, (o & ((se & sv) | (~se & l))) | (~o & x), o | m);
      rd(ADDR_DRIVE_STAT, o, 32'hFFFFFFFF);
    end
    SER_OVR_EN <= 8'h00;
    ext_en <= 8'h0F;
    ext_val <= 8'h0F;
    {CAPTURE_COMPARE_UNIT_TWO_EN, ECCP_EN, SPI_CLK_EN, CAPTURE_COMPARE_UNIT_TWO_OUT, ECCP_OUT, SPI_CLK_OUT} <= 6'h3F;
    wr(ADDR_DIRECTION, 8'hFF);
    wr(ADDR_OUT_LATCH, 8'h00);
    WSTRB <= 4'hE;
    wr(ADDR_OUT_LATCH, 8'hA5);
    WSTRB <= 4'hF;
    rd(ADDR_OUT_LATCH, 32'h0, 32'hFFFFFFFF);
    repeat (5) @(posedge CLOCK);
    chk({CAPTURE_COMPARE_UNIT_TWO_CAPTURE_IN, ECCP_CAPTURE_IN, SPI_CLK_IN, PIN_OE}, 11'h700);
    chk(COUNTER_CLK_IN, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    repeat (5) @(posedge CLOCK);
    chk(CAPTURE_COMPARE_UNIT_TWO_CAPTURE_IN, 1'b0);
    ext_en <= 8'h00;
    wr(ADDR_CONTROL, 8'h06);
    wr(ADDR_DIRECTION, 8'hF0);
    repeat (3) @(posedge CLOCK);
    chk({PIN_OE[3:1], PIN_OUT[3:1]}, 6'h3F);
    PWM_SHUTDOWN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    chk(PIN_OE[2], 1'b0);
    wr(ADDR_CONTROL, 8'h03);
    repeat (3) @(posedge CLOCK);
    chk({OSC_ACTIVE, PIN_OE[1:0]}, 3'h4);
    rd(ADDR_PIN_DATA, 32'h0, 32'h3);
    wr(8'h14, 8'h5A);
    rd(8'h14, 32'h0, 32'hFFFFFFFF);
    NRST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    chk({OSC_ACTIVE, PIN_OE}, 9'h000);
    rd(ADDR_DIRECTION, 32'hFF, 32'hFFFFFFFF);
    test_done();
  end
endmodule
`default_nettype wire

//--- bench/pcio_props.sv
// assertion checker on the port block's top-level pins
`timescale 1ns/100ps
`default_nettype none
module pcio_props (
  input wire logic        CLOCK,          // core clock
  input wire logic        NRST,           // reset, low
  input wire logic        AWVALID,        // aw valid
  input wire logic        AWREADY,        // aw ready
  input wire logic        WVALID,         // w valid
  input wire logic        WREADY,         // w ready
  input wire logic        BVALID,         // b valid
  input wire logic        BREADY,         // b ready
  input wire logic [1:0]  BRESP,          // b resp
  input wire logic        ARVALID,        // ar valid
  input wire logic        ARREADY,        // ar ready
  input wire logic        RVALID,         // r valid
  input wire logic        RREADY,         // r ready
  input wire logic [31:0] RDATA,          // r data
  input wire logic [7:0]  PIN_OUT,        // drive value
  input wire logic [7:0]  PIN_OE,         // drive enable
  input wire logic [7:0]  SER_OVR_EN,     // serial force
  input wire logic [7:0]  SER_OVR_DRIVE,  // forced oe
  input wire logic [7:0]  SER_OVR_DATA,   // forced value
  input wire logic        OSC_ACTIVE,     // oscillator on
  input wire logic [7:0]  PERIPH_IN       // sampled pins
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  property p_rst;
    disable iff (1'b0) !NRST |-> PIN_OE == 8'h00 && !BVALID && !RVALID;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs active in reset");
  property p_osc_oe;
    OSC_ACTIVE && $past(OSC_ACTIVE) |-> PIN_OE[1:0] == 2'h0;
  endproperty
  a_osc_oe: assert property (p_osc_oe) else $error("oscillator pin driven");
  property p_osc_in;
    OSC_ACTIVE && $past(OSC_ACTIVE) |-> PERIPH_IN[1:0] == 2'h0;
  endproperty
  a_osc_in: assert property (p_osc_in) else $error("oscillator pin read digital");
  property p_ser;
    SER_OVR_EN[7] |=> PIN_OE[7] == $past(SER_OVR_DRIVE[7])
      && (!PIN_OE[7] || PIN_OUT[7] == $past(SER_OVR_DATA[7]));
  endproperty
  a_ser: assert property (p_ser) else $error("serial force ignored");
  property p_bresp;
    AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY && !WREADY ##1 BVALID;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write answer late");
  property p_rresp;
    ARVALID && ARREADY |=> RVALID && !ARREADY;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_bhold;
    BVALID && !BREADY |=> BVALID && $stable(BRESP);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    RVALID && !RREADY |=> RVALID && $stable(RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_upper;
    RVALID |-> RDATA[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  c_wr: cover property (BVALID && BREADY);
  c_rd: cover property (RVALID && RREADY);
  c_osc: cover property (OSC_ACTIVE);
endmodule
bind pcio_port pcio_props i_props (.CLOCK(CLOCK), .NRST(NRST), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
  .RDATA(RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .SER_OVR_EN(SER_OVR_EN),
  .SER_OVR_DRIVE(SER_OVR_DRIVE), .SER_OVR_DATA(SER_OVR_DATA), .OSC_ACTIVE(OSC_ACTIVE),
  .PERIPH_IN(PERIPH_IN));
`default_nettype wire

//--- rtl/pcio_mux_if.sv
// configuration and peripheral signals into the pin multiplexer, drive back out
`timescale 1ns/100ps
`default_nettype none
interface pcio_mux_if;
  import pcio_pkg::*;
  logic [PORT_WIDTH-1:0] direction;
  logic [PORT_WIDTH-1:0] latch;
  logic                  osc_en;
  logic                  relocate;
  logic                  tristate_cfg;
  logic                  capture_compare_unit_two_en;
  logic                  capture_compare_unit_two_out;
  logic                  eccp_en;
  logic                  eccp_out;
  logic                  pwm_shutdown;
  logic                  spi_clk_en;
  logic                  spi_clk_out;
  logic [PORT_WIDTH-1:0] ovr_en;
  logic [PORT_WIDTH-1:0] ovr_drive;
  logic [PORT_WIDTH-1:0] ovr_data;
  logic [PORT_WIDTH-1:0] pin_out;
  logic [PORT_WIDTH-1:0] pin_oe;

  modport ctrl (output direction, latch, osc_en, relocate, tristate_cfg, capture_compare_unit_two_en, capture_compare_unit_two_out,
                output eccp_en, eccp_out, pwm_shutdown, spi_clk_en, spi_clk_out,
                output ovr_en, ovr_drive, ovr_data, input pin_out, pin_oe);
  modport mux  (input direction, latch, osc_en, relocate, tristate_cfg, capture_compare_unit_two_en, capture_compare_unit_two_out,
                input eccp_en, eccp_out, pwm_shutdown, spi_clk_en, spi_clk_out,
                input ovr_en, ovr_drive, ovr_data, output pin_out, pin_oe);
endinterface
`default_nettype wire

//--- rtl/pcio_pin_mux.sv
// per-pin drive selection between latch, peripherals and the oscillator
`timescale 1ns/100ps
`default_nettype none
module pcio_pin_mux (
  pcio_mux_if.mux bus  // configuration in, pin drive out
);
  import pcio_pkg::*;

  genvar i;
  generate
    for (i = 0; i < PORT_WIDTH; i = i + 1) begin : g_pin
      always_comb begin
        // plain port function
        bus.pin_oe[i]  = ~bus.direction[i];
        bus.pin_out[i] = bus.latch[i];
        if (i == PIN_CAPTURE2 && bus.relocate && bus.capture_compare_unit_two_en && !bus.direction[i]) begin
          bus.pin_out[i] = bus.capture_compare_unit_two_out;
        end
        if (i == PIN_ENHANCED && bus.eccp_en && !bus.direction[i]) begin
          bus.pin_out[i] = bus.eccp_out;
          if (bus.pwm_shutdown && bus.tristate_cfg) begin
            bus.pin_oe[i] = 1'b0;
          end
        end
        if (i == PIN_SPI_CLOCK && bus.spi_clk_en && !bus.direction[i]) begin
          bus.pin_out[i] = bus.spi_clk_out;
        end
        // serial units force direction regardless of the direction bit
        if (bus.ovr_en[i]) begin
          bus.pin_oe[i]  = bus.ovr_drive[i];
          bus.pin_out[i] = bus.ovr_data[i];
        end
        // oscillator owns the two low pins as analog
        if ((i == PIN_OSC_OUT || i == PIN_OSC_IN) && bus.osc_en) begin
          bus.pin_oe[i]  = 1'b0;
          bus.pin_out[i] = 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- rtl/pcio_pkg.sv
// shared constants and types for the general-purpose port block
package pcio_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;

  // register byte addresses
  localparam logic [ADDR_WIDTH-1:0] ADDR_PIN_DATA   = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] ADDR_OUT_LATCH  = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] ADDR_DIRECTION  = 8'h08;
  localparam logic [ADDR_WIDTH-1:0] ADDR_CONTROL    = 8'h0C;
  localparam logic [ADDR_WIDTH-1:0] ADDR_DRIVE_STAT = 8'h10;

  // control register fields
  localparam int CTRL_OSC_EN_BIT   = 0;
  localparam int CTRL_RELOCATE_BIT = 1;
  localparam int CTRL_TRISTATE_BIT = 2;
  localparam int CTRL_WIDTH        = 3;

  // reset values
  localparam logic [PORT_WIDTH-1:0] RESET_DIRECTION = 8'hFF;
  localparam logic [PORT_WIDTH-1:0] RESET_LATCH     = 8'h00;
  localparam logic [CTRL_WIDTH-1:0] RESET_CONTROL   = 3'h2;

  // pin assignments of the peripheral functions
  localparam int PIN_OSC_OUT   = 0;
  localparam int PIN_OSC_IN    = 1;
  localparam int PIN_CAPTURE2  = 1;
  localparam int PIN_ENHANCED  = 2;
  localparam int PIN_SPI_CLOCK = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {
    PCIO_REG_PIN_DATA,
    PCIO_REG_OUT_LATCH,
    PCIO_REG_DIRECTION,
    PCIO_REG_CONTROL,
    PCIO_REG_DRIVE_STAT,
    PCIO_REG_NONE
  } pcio_reg_t;
endpackage

//--- rtl/pcio_port.sv
// eight-pin bidirectional port with AXI4-Lite registers and peripheral overrides
//
// Overview of operation
// - Eight pins, each with own direction, output latch and sampled input bit.
// - Direction bit one turns the pin driver off; pin is input only.
// - Direction bit zero drives the pin from its output latch bit.
// - Latch register is addressable and reads back latched values, not pins.
// - Capture unit two uses pin one unless relocate bit cleared; bit resets to one.
// - Enabled serial units force pin direction and data despite direction bits.
// - After power-on reset every pin is a digital input.
// - Direction register reads stored bits even while peripherals override pins.
// - Timer oscillator enabled takes pins zero and one as analog, digital off.
// - Pin one: unit two output overrides latch when output; else feeds capture.
// - Pin two: enhanced unit output overrides latch when output; else capture.
// - Enhanced channel A overrides data and may float during shutdown.
// - Pin three: SPI clock output overrides data when output; else clock input.
`timescale 1ns/100ps
`default_nettype none
module pcio_port (
  input  wire logic                            CLOCK,            // core clock
  input  wire logic                            NRST,             // async reset, low
  input  wire logic [pcio_pkg::ADDR_WIDTH-1:0] AWADDR,           // write address
  input  wire logic                            AWVALID,          // write address valid
  output logic                                 AWREADY,          // write address ready
  input  wire logic [pcio_pkg::DATA_WIDTH-1:0] WDATA,            // write data
  input  wire logic [3:0]                      WSTRB,            // write byte enables
  input  wire logic                            WVALID,           // write data valid
  output logic                                 WREADY,           // write data ready
  output logic [1:0]                           BRESP,            // write response
  output logic                                 BVALID,           // write response valid
  input  wire logic                            BREADY,           // write response ready
  input  wire logic [pcio_pkg::ADDR_WIDTH-1:0] ARADDR,           // read address
  input  wire logic                            ARVALID,          // read address valid
  output logic                                 ARREADY,          // read address ready
  output logic [pcio_pkg::DATA_WIDTH-1:0]      RDATA,            // read data
  output logic [1:0]                           RRESP,            // read response
  output logic                                 RVALID,           // read data valid
  input  wire logic                            RREADY,           // read data ready
  input  wire logic [pcio_pkg::PORT_WIDTH-1:0] PIN_IN,           // pin levels
  output logic [pcio_pkg::PORT_WIDTH-1:0]      PIN_OUT,          // pin drive value
  output logic [pcio_pkg::PORT_WIDTH-1:0]      PIN_OE,           // pin driver enable
  input  wire logic                            CAPTURE_COMPARE_UNIT_TWO_EN,          // unit two output on
  input  wire logic                            CAPTURE_COMPARE_UNIT_TWO_OUT,         // unit two compare/pwm
  input  wire logic                            ECCP_EN,          // enhanced unit on
  input  wire logic                            ECCP_OUT,         // enhanced channel A
  input  wire logic                            PWM_SHUTDOWN,     // shutdown event level
  input  wire logic                            SPI_CLK_EN,       // spi clock out on
  input  wire logic                            SPI_CLK_OUT,      // spi clock value
  input  wire logic [pcio_pkg::PORT_WIDTH-1:0] SER_OVR_EN,       // serial forcing pin
  input  wire logic [pcio_pkg::PORT_WIDTH-1:0] SER_OVR_DRIVE,    // forced as output
  input  wire logic [pcio_pkg::PORT_WIDTH-1:0] SER_OVR_DATA,     // forced value
  output logic                                 OSC_ACTIVE,       // pins 0/1 analog
  output logic                                 CAPTURE_COMPARE_UNIT_TWO_CAPTURE_IN,  // unit two capture
  output logic                                 ECCP_CAPTURE_IN,  // enhanced capture
  output logic                                 SPI_CLK_IN,       // spi clock input
  output logic                                 COUNTER_CLK_IN,   // timer counter input
  output logic [pcio_pkg::PORT_WIDTH-1:0]      PERIPH_IN         // sampled digital pins
);
  import pcio_pkg::*;

  logic [PORT_WIDTH-1:0] direction;
  logic [PORT_WIDTH-1:0] latch;
  logic [CTRL_WIDTH-1:0] control;
  logic [PORT_WIDTH-1:0] pin_meta;
  logic [PORT_WIDTH-1:0] pin_sync;
  logic [PORT_WIDTH-1:0] digital_in;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [DATA_WIDTH-1:0] w_data;
  logic [3:0]            w_strb;
  logic                  aw_have;
  logic                  w_have;
  logic                  wr_fire;
  pcio_reg_t             wr_reg;
  pcio_reg_t             rd_reg;
  logic [DATA_WIDTH-1:0] next_rdata;

  pcio_mux_if mux_bus ();

  // address to register decode, shared by both channels
  function automatic pcio_reg_t decode_reg(input logic [ADDR_WIDTH-1:0] addr);
    case (addr)
      ADDR_PIN_DATA:   decode_reg = PCIO_REG_PIN_DATA;
      ADDR_OUT_LATCH:  decode_reg = PCIO_REG_OUT_LATCH;
      ADDR_DIRECTION:  decode_reg = PCIO_REG_DIRECTION;
      ADDR_CONTROL:    decode_reg = PCIO_REG_CONTROL;
      ADDR_DRIVE_STAT: decode_reg = PCIO_REG_DRIVE_STAT;
      default:         decode_reg = PCIO_REG_NONE;
    endcase
  endfunction

  // two-flop synchroniser on the pins
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  // oscillator pins read as zero while analog
  always_comb begin
    digital_in = pin_sync;
    if (control[CTRL_OSC_EN_BIT]) begin
      digital_in[PIN_OSC_OUT] = 1'b0;
      digital_in[PIN_OSC_IN]  = 1'b0;
    end
  end

  // write address and data channels, taken in either order
  assign wr_fire = aw_have && w_have && !BVALID;
  assign wr_reg  = decode_reg(aw_addr);

  // write address channel, closed until the response is taken
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      AWREADY <= 1'b1;
      aw_have <= 1'b0;
      aw_addr <= '0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_have <= 1'b1;
        aw_addr <= AWADDR;
        AWREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
      end
      if (BVALID && BREADY) begin
        AWREADY <= 1'b1;
      end
    end
  end

  // write data channel, closed until the response is taken
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      WREADY <= 1'b1;
      w_have <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (WVALID && WREADY) begin
        w_have <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
        WREADY <= 1'b0;
      end
      if (wr_fire) begin
        w_have <= 1'b0;
      end
      if (BVALID && BREADY) begin
        WREADY <= 1'b1;
      end
    end
  end

  // write response, raised once both halves are held
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      BVALID <= 1'b0;
      BRESP  <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        BVALID <= 1'b1;
        BRESP  <= (wr_reg == PCIO_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // software registers; only the low byte lane carries data
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      direction <= RESET_DIRECTION;
      latch     <= RESET_LATCH;
      control   <= RESET_CONTROL;
    end else if (wr_fire && w_strb[0]) begin
      case (wr_reg)
        PCIO_REG_PIN_DATA:  latch <= w_data[PORT_WIDTH-1:0];
        PCIO_REG_OUT_LATCH: latch <= w_data[PORT_WIDTH-1:0];
        PCIO_REG_DIRECTION: direction <= w_data[PORT_WIDTH-1:0];
        PCIO_REG_CONTROL:   control <= w_data[CTRL_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  // read data selection
  assign rd_reg = decode_reg(ARADDR);

  always_comb begin
    next_rdata = '0;
    case (rd_reg)
      PCIO_REG_PIN_DATA:   next_rdata[PORT_WIDTH-1:0] = digital_in;
      PCIO_REG_OUT_LATCH:  next_rdata[PORT_WIDTH-1:0] = latch;
      PCIO_REG_DIRECTION:  next_rdata[PORT_WIDTH-1:0] = direction;
      PCIO_REG_CONTROL:    next_rdata[CTRL_WIDTH-1:0] = control;
      PCIO_REG_DRIVE_STAT: next_rdata[PORT_WIDTH-1:0] = PIN_OE;
      default:             next_rdata = '0;
    endcase
  end

  // read address channel, one read in flight
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b1;
    end else begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
      end
      if (RVALID && RREADY) begin
        ARREADY <= 1'b1;
      end
    end
  end

  // read data, captured at the address handshake and held until taken
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      RVALID <= 1'b0;
      RDATA  <= '0;
      RRESP  <= RESP_OKAY;
    end else begin
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RDATA  <= next_rdata;
        RRESP  <= (rd_reg == PCIO_REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // multiplexer hookup
  assign mux_bus.direction    = direction;
  assign mux_bus.latch        = latch;
  assign mux_bus.osc_en       = control[CTRL_OSC_EN_BIT];
  assign mux_bus.relocate     = control[CTRL_RELOCATE_BIT];
  assign mux_bus.tristate_cfg = control[CTRL_TRISTATE_BIT];
  assign mux_bus.capture_compare_unit_two_en      = CAPTURE_COMPARE_UNIT_TWO_EN;
  assign mux_bus.capture_compare_unit_two_out     = CAPTURE_COMPARE_UNIT_TWO_OUT;
  assign mux_bus.eccp_en      = ECCP_EN;
  assign mux_bus.eccp_out     = ECCP_OUT;
  assign mux_bus.pwm_shutdown = PWM_SHUTDOWN;
  assign mux_bus.spi_clk_en   = SPI_CLK_EN;
  assign mux_bus.spi_clk_out  = SPI_CLK_OUT;
  assign mux_bus.ovr_en       = SER_OVR_EN;
  assign mux_bus.ovr_drive    = SER_OVR_DRIVE;
  assign mux_bus.ovr_data     = SER_OVR_DATA;

  pcio_pin_mux u_mux (
    .bus (mux_bus.mux)
  );

  // registered pin drive and peripheral inputs
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      PIN_OUT <= '0;
      PIN_OE  <= '0;
    end else begin
      PIN_OUT <= mux_bus.pin_out;
      PIN_OE  <= mux_bus.pin_oe;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      OSC_ACTIVE      <= 1'b0;
      CAPTURE_COMPARE_UNIT_TWO_CAPTURE_IN <= 1'b0;
      ECCP_CAPTURE_IN <= 1'b0;
      SPI_CLK_IN      <= 1'b0;
      COUNTER_CLK_IN  <= 1'b0;
      PERIPH_IN       <= '0;
    end else begin
      OSC_ACTIVE      <= control[CTRL_OSC_EN_BIT];
      CAPTURE_COMPARE_UNIT_TWO_CAPTURE_IN <= control[CTRL_RELOCATE_BIT] && direction[PIN_CAPTURE2]
                         && digital_in[PIN_CAPTURE2];
      ECCP_CAPTURE_IN <= direction[PIN_ENHANCED] && digital_in[PIN_ENHANCED];
      SPI_CLK_IN      <= direction[PIN_SPI_CLOCK] && digital_in[PIN_SPI_CLOCK];
      COUNTER_CLK_IN  <= direction[PIN_OSC_OUT] && digital_in[PIN_OSC_OUT];
      PERIPH_IN       <= digital_in;
    end
  end
endmodule
`default_nettype wire
